// ---- design/nstre_addr_if.sv ----
// Carrier between the executor and its operand address resolver.
// Assumes purely combinational use within one clock domain.
`timescale 1ns/1ps
interface nstre_addr_if;
    import nstre_pkg::*;

    logic [7:0]        file_field;
    logic              access_bit;
    logic [BANK_W-1:0] bank_sel;
    logic              ext_en;
    logic [ADDR_W-1:0] index_base;
    logic [ADDR_W-1:0] addr;
    logic              indexed;

    modport resolver (
        input  file_field,
        input  access_bit,
        input  bank_sel,
        input  ext_en,
        input  index_base,
        output addr,
        output indexed
    );

    modport requester (
        output file_field,
        output access_bit,
        output bank_sel,
        output ext_en,
        output index_base,
        input  addr,
        input  indexed
    );
endinterface

// ---- design/nstre_addr_resolve.sv ----
// Operand address resolver for byte-oriented file register access.
// Assumes its inputs are stable while the executor decodes.
`timescale 1ns/1ps
module nstre_addr_resolve
    import nstre_pkg::*;
(
    nstre_addr_if.resolver ai
);

    // ------------------------------------------------------------------
    // Address selection
    // ------------------------------------------------------------------
    // Indexed mode only in the lower access window with the extended set
    always_comb begin
        ai.indexed = 1'b0;
        if (ai.access_bit) begin
            ai.addr = {ai.bank_sel, ai.file_field};
        end else if (ai.ext_en && (ai.file_field <= ACCESS_LIMIT)) begin
            ai.indexed = 1'b1;
            ai.addr    = ai.index_base + {6'h00, ai.file_field};
        end else if (ai.file_field <= ACCESS_LIMIT) begin
            ai.addr = {ACCESS_LO_BANK, ai.file_field};
        end else begin
            ai.addr = {ACCESS_HI_BANK, ai.file_field};
        end
    end

endmodule

// ---- design/nstre_exec.sv ----
// Executor for the nibble swap and table read instructions.
// Assumes one system clock per quarter phase; the core offers an
// instruction only in the first quarter and holds fetch while busy.
`timescale 1ns/1ps
module nstre_exec
    import nstre_pkg::*;
(
    input  wire logic              SYS_CLK_IN,
    input  wire logic              RST_N_IN,
    input  wire logic              INSTR_VALID_IN,
    input  wire logic [15:0]       INSTR_IN,
    input  wire logic [BANK_W-1:0] BANK_SELECT_IN,
    input  wire logic              EXT_SET_EN_IN,
    input  wire logic [ADDR_W-1:0] INDEX_BASE_IN,
    input  wire logic [7:0]        FILE_RD_DATA_IN,
    input  wire logic [15:0]       PM_DATA_IN,
    input  wire logic              PTR_WR_EN_IN,
    input  wire logic [PTR_W-1:0]  PTR_WR_DATA_IN,
    output logic [1:0]             QUARTER_OUT,
    output logic                   BUSY_OUT,
    output logic                   FILE_RD_EN_OUT,
    output logic [ADDR_W-1:0]      FILE_ADDR_OUT,
    output logic                   INDEXED_OUT,
    output logic                   FILE_WR_EN_OUT,
    output logic                   WREG_WR_EN_OUT,
    output logic [7:0]             RESULT_OUT,
    output logic                   PM_RD_EN_OUT,
    output logic [PTR_W-2:0]       PM_WORD_ADDR_OUT,
    output logic                   TABLE_DONE_OUT,
    output logic [7:0]             TABLE_LATCH_OUT,
    output logic [PTR_W-1:0]       TABLE_POINTER_OUT
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    nstre_state_t      state_q, state_d;
    logic [1:0]        qtr_q, qtr_d;
    logic [15:0]       instr_q, instr_d;
    logic [1:0]        mode_q, mode_d;
    logic              second_q, second_d;
    logic              rd_hi_q, rd_hi_d;
    logic              busy_q, busy_d;
    logic              frd_q, frd_d;
    logic [ADDR_W-1:0] faddr_q, faddr_d;
    logic              idx_q, idx_d;
    logic              fwr_q, fwr_d;
    logic              wwr_q, wwr_d;
    logic [7:0]        res_q, res_d;
    logic              pmrd_q, pmrd_d;
    logic [PTR_W-2:0]  pmaddr_q, pmaddr_d;
    logic              done_q, done_d;
    logic [7:0]        latch_q, latch_d;
    logic [PTR_W-1:0]  ptr_q, ptr_d;
    logic              dec_swap, dec_tbl;

    nstre_addr_if ai ();

    nstre_addr_resolve u_resolve (
        .ai (ai.resolver)
    );

    // Operands come straight from the instruction offered in Q1
    assign ai.file_field = INSTR_IN[7:0];
    assign ai.access_bit = INSTR_IN[ACCESS_BIT];
    assign ai.bank_sel   = BANK_SELECT_IN;
    assign ai.ext_en     = EXT_SET_EN_IN;
    assign ai.index_base = INDEX_BASE_IN;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    assign dec_swap = (INSTR_IN[15:10] == SWAP_OPC);
    assign dec_tbl  = (INSTR_IN[15:2] == TABLE_READ_OPC);

    // Next values for the whole sequencer; pulses default low
    always_comb begin
        state_d  = state_q;
        qtr_d    = qtr_q + 2'h1;
        instr_d  = instr_q;
        mode_d   = mode_q;
        second_d = second_q;
        rd_hi_d  = rd_hi_q;
        frd_d    = 1'b0;
        faddr_d  = faddr_q;
        idx_d    = idx_q;
        fwr_d    = 1'b0;
        wwr_d    = 1'b0;
        res_d    = res_q;
        pmrd_d   = 1'b0;
        pmaddr_d = pmaddr_q;
        done_d   = 1'b0;
        latch_d  = latch_q;
        ptr_d    = ptr_q;
        case (state_q)
            ST_IDLE: begin
                // Core pointer loads only land between instructions
                if (PTR_WR_EN_IN) begin
                    ptr_d = PTR_WR_DATA_IN;
                end
                if (qtr_q == QTR_1 && INSTR_VALID_IN && dec_swap) begin
                    state_d = ST_SWAP;
                    instr_d = INSTR_IN;
                    faddr_d = ai.addr;
                    idx_d   = ai.indexed;
                    frd_d   = 1'b1;
                end else if (qtr_q == QTR_1 && INSTR_VALID_IN && dec_tbl) begin
                    state_d  = ST_TBL;
                    instr_d  = INSTR_IN;
                    mode_d   = INSTR_IN[1:0];
                    second_d = 1'b0;
                end
            end
            ST_SWAP: begin
                // Process in Q2 so the write is ready for Q4
                if (qtr_q == QTR_2) begin
                    res_d = nib_swap(FILE_RD_DATA_IN);
                end else if (qtr_q == QTR_3) begin
                    fwr_d = instr_q[DEST_BIT];
                    wwr_d = !instr_q[DEST_BIT];
                end else if (qtr_q == QTR_4) begin
                    state_d = ST_IDLE;
                end
            end
            ST_TBL: begin
                if (!second_q) begin
                    // Pre-increment lands before the read cycle starts
                    if (qtr_q == QTR_3 && mode_q == MODE_PRE_INC) begin
                        ptr_d = ptr_step(ptr_q, 1'b0);
                    end else if (qtr_q == QTR_4) begin
                        second_d = 1'b1;
                    end
                end else begin
                    if (qtr_q == QTR_1) begin
                        pmrd_d   = 1'b1;
                        pmaddr_d = ptr_q[PTR_W-1:1];
                        rd_hi_d  = ptr_q[0];
                    end else if (qtr_q == QTR_3) begin
                        latch_d = rd_hi_q ? PM_DATA_IN[15:8] : PM_DATA_IN[7:0];
                        done_d  = 1'b1;
                        if (mode_q == MODE_POST_INC) begin
                            ptr_d = ptr_step(ptr_q, 1'b0);
                        end else if (mode_q == MODE_POST_DEC) begin
                            ptr_d = ptr_step(ptr_q, 1'b1);
                        end
                    end else if (qtr_q == QTR_4) begin
                        state_d = ST_IDLE;
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        busy_d = (state_d != ST_IDLE);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            state_q  <= ST_IDLE;
            qtr_q    <= QTR_1;
            instr_q  <= 16'h0000;
            mode_q   <= MODE_KEEP;
            second_q <= 1'b0;
            rd_hi_q  <= 1'b0;
            busy_q   <= 1'b0;
            frd_q    <= 1'b0;
            faddr_q  <= 14'h0000;
            idx_q    <= 1'b0;
            fwr_q    <= 1'b0;
            wwr_q    <= 1'b0;
            res_q    <= BYTE_ZERO;
            pmrd_q   <= 1'b0;
            pmaddr_q <= 20'h00000;
            done_q   <= 1'b0;
            latch_q  <= BYTE_ZERO;
            ptr_q    <= PTR_RESET;
        end else begin
            state_q  <= state_d;
            qtr_q    <= qtr_d;
            instr_q  <= instr_d;
            mode_q   <= mode_d;
            second_q <= second_d;
            rd_hi_q  <= rd_hi_d;
            busy_q   <= busy_d;
            frd_q    <= frd_d;
            faddr_q  <= faddr_d;
            idx_q    <= idx_d;
            fwr_q    <= fwr_d;
            wwr_q    <= wwr_d;
            res_q    <= res_d;
            pmrd_q   <= pmrd_d;
            pmaddr_q <= pmaddr_d;
            done_q   <= done_d;
            latch_q  <= latch_d;
            ptr_q    <= ptr_d;
        end
    end

    // Outputs straight from flops
    assign QUARTER_OUT       = qtr_q;
    assign BUSY_OUT          = busy_q;
    assign FILE_RD_EN_OUT    = frd_q;
    assign FILE_ADDR_OUT     = faddr_q;
    assign INDEXED_OUT       = idx_q;
    assign FILE_WR_EN_OUT    = fwr_q;
    assign WREG_WR_EN_OUT    = wwr_q;
    assign RESULT_OUT        = res_q;
    assign PM_RD_EN_OUT      = pmrd_q;
    assign PM_WORD_ADDR_OUT  = pmaddr_q;
    assign TABLE_DONE_OUT    = done_q;
    assign TABLE_LATCH_OUT   = latch_q;
    assign TABLE_POINTER_OUT = ptr_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    logic [7:0] pm_sel_a;
    logic [7:0] rd_sw_a;
    // Independent of the datapath: pointer bit and explicit nibble order
    assign pm_sel_a = TABLE_POINTER_OUT[0] ? PM_DATA_IN[15:8] : PM_DATA_IN[7:0];
    assign rd_sw_a  = {FILE_RD_DATA_IN[3:0], FILE_RD_DATA_IN[7:4]};

    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    a_swap_decode: assert property (
        (state_q == ST_IDLE && qtr_q == QTR_1 && INSTR_VALID_IN && dec_swap)
        |=> state_q == ST_SWAP && FILE_RD_EN_OUT) else $error("swap not decoded");
    a_swap_nibbles: assert property (
        (FILE_WR_EN_OUT || WREG_WR_EN_OUT) |-> RESULT_OUT == $past(rd_sw_a, 2))
        else $error("swap result wrong");
    a_dest_select: assert property (
        (FILE_WR_EN_OUT |-> instr_q[DEST_BIT]) and (WREG_WR_EN_OUT |-> !instr_q[DEST_BIT]))
        else $error("wrong destination");
    a_bank_addr: assert property (
        $rose(FILE_RD_EN_OUT) && instr_q[ACCESS_BIT]
        |-> FILE_ADDR_OUT == {$past(BANK_SELECT_IN), instr_q[7:0]}) else $error("bank address");
    a_indexed_addr: assert property (
        $rose(FILE_RD_EN_OUT) && !instr_q[ACCESS_BIT] && $past(EXT_SET_EN_IN)
        && instr_q[7:0] <= ACCESS_LIMIT
        |-> INDEXED_OUT && FILE_ADDR_OUT == $past(INDEX_BASE_IN) + {6'h00, instr_q[7:0]})
        else $error("indexed address");
    a_swap_timing: assert property (
        state_q == ST_SWAP && qtr_q == QTR_2
        |-> ##2 (qtr_q == QTR_4 && (FILE_WR_EN_OUT || WREG_WR_EN_OUT))) else $error("swap late");
    a_tbl_read_q2: assert property (
        PM_RD_EN_OUT |-> qtr_q == QTR_2 && second_q ##2 TABLE_DONE_OUT && qtr_q == QTR_4)
        else $error("table read timing");
    a_tbl_addr_src: assert property (
        PM_RD_EN_OUT |-> PM_WORD_ADDR_OUT == TABLE_POINTER_OUT[PTR_W-1:1])
        else $error("table address source");
    a_byte_select: assert property (
        TABLE_DONE_OUT |-> TABLE_LATCH_OUT == $past(pm_sel_a)) else $error("byte select");
    a_ptr_post_inc: assert property (
        TABLE_DONE_OUT && mode_q == MODE_POST_INC
        |-> TABLE_POINTER_OUT == $past(TABLE_POINTER_OUT) + 21'h000001)
        else $error("post increment");
    a_ptr_post_dec: assert property (
        TABLE_DONE_OUT && mode_q == MODE_POST_DEC
        |-> TABLE_POINTER_OUT == $past(TABLE_POINTER_OUT) - 21'h000001)
        else $error("post decrement");
    a_ptr_pre_inc: assert property (
        TABLE_DONE_OUT && mode_q == MODE_PRE_INC
        |-> TABLE_POINTER_OUT == $past(TABLE_POINTER_OUT, 5) + 21'h000001)
        else $error("pre increment");

    c_swap_wreg: cover property (WREG_WR_EN_OUT);
    c_swap_file: cover property (FILE_WR_EN_OUT && INDEXED_OUT);
    c_tbl_pre:   cover property (TABLE_DONE_OUT && mode_q == MODE_PRE_INC);
    c_tbl_dec:   cover property (TABLE_DONE_OUT && mode_q == MODE_POST_DEC && rd_hi_q);

endmodule

// ---- design/nstre_pkg.sv ----
// Shared constants for the nibble swap / table read execution block.
// Assumes a core that runs four quarter phases per instruction cycle,
// one system clock per quarter.
package nstre_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 14;            // Data memory address
    localparam int BANK_W = 6;             // Bank select width
    localparam int PTR_W  = 21;            // Table pointer, byte address

    // ------------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------------
    localparam logic [5:0]  SWAP_OPC     = 6'h0e;    // Bits 15:10
    localparam logic [13:0] TABLE_READ_OPC = 14'h0002; // Bits 15:2
    localparam int          DEST_BIT     = 9;
    localparam int          ACCESS_BIT   = 8;

    // ------------------------------------------------------------------
    // Addressing
    // ------------------------------------------------------------------
    localparam logic [7:0]        ACCESS_LIMIT   = 8'h5f;
    localparam logic [BANK_W-1:0] ACCESS_LO_BANK = 6'h00;
    localparam logic [BANK_W-1:0] ACCESS_HI_BANK = 6'h3f;

    // ------------------------------------------------------------------
    // Quarter phases and pointer modes
    // ------------------------------------------------------------------
    localparam logic [1:0] QTR_1 = 2'h0;
    localparam logic [1:0] QTR_2 = 2'h1;
    localparam logic [1:0] QTR_3 = 2'h2;
    localparam logic [1:0] QTR_4 = 2'h3;

    localparam logic [1:0] MODE_KEEP     = 2'h0;
    localparam logic [1:0] MODE_POST_INC = 2'h1;
    localparam logic [1:0] MODE_POST_DEC = 2'h2;
    localparam logic [1:0] MODE_PRE_INC  = 2'h3;

    localparam logic [PTR_W-1:0] PTR_RESET = 21'h000000;
    localparam logic [7:0]       BYTE_ZERO = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SWAP = 3'b010,
        ST_TBL  = 3'b100
    } nstre_state_t;

    // Exchange upper and lower nibble
    function automatic logic [7:0] nib_swap(input logic [7:0] v);
        nib_swap = {v[3:0], v[7:4]};
    endfunction

    // Step the pointer across all bits, wrapping at the ends
    function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p,
                                                  input logic              down);
        ptr_step = down ? p - 21'h000001 : p + 21'h000001;
    endfunction

endpackage

// ---- tb/nstre_core_model.sv ----
// Far-side model: file register array and program memory for the executor.
// Assumes the executor's strobes and addresses come from flops on the rising edge.
`timescale 1ns/1ps
module nstre_core_model
    import nstre_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              file_rd_en_in,
    input  wire logic [ADDR_W-1:0] file_addr_in,
    input  wire logic              pm_rd_en_in,
    input  wire logic [PTR_W-2:0]  pm_word_addr_in,
    output logic [7:0]             file_data_out,
    output logic [15:0]            pm_data_out
);
    logic [7:0]  file_last_q = 8'h00;
    logic [15:0] pm_q        = 16'h0000;
    logic        pm_live_q   = 1'b0;

    // Contents are a fixed mix of the low address byte, so a slip in those eight bits shows
    function automatic logic [7:0] file_byte(input logic [ADDR_W-1:0] a);
        return a[7:0] ^ 8'ha5;
    endfunction

    function automatic logic [15:0] pm_word(input logic [PTR_W-2:0] w);
        return {w[7:0] ^ 8'h96, w[7:0] ^ 8'h3c};
    endfunction

    // Released bus shows the inverse, never a stale match
    assign file_data_out = file_rd_en_in ? file_byte(file_addr_in) : ~file_last_q;
    assign pm_data_out   = pm_live_q ? pm_q : ~pm_q;

    // Word appears only in the quarter after the read strobe
    always @(posedge clk_in) begin
        if (file_rd_en_in) begin
            file_last_q <= file_byte(file_addr_in);
        end
        pm_live_q <= pm_rd_en_in;
        if (pm_rd_en_in) begin
            pm_q <= pm_word(pm_word_addr_in);
        end
    end
endmodule

// ---- tb/nstre_exec_tb.sv ----
// Self-checking bench for the nibble swap / table read executor.
// Assumes one clock per quarter; inputs change on the falling edge.
`timescale 1ns/1ps
module nstre_exec_tb;
    import nstre_pkg::*;

    logic              clk      = 1'b0;
    logic              rst_n    = 1'b0;
    logic              valid    = 1'b0;
    logic [15:0]       instr    = 16'h0000;
    logic [BANK_W-1:0] bank     = 6'h00;
    logic              ext      = 1'b0;
    logic [ADDR_W-1:0] base     = 14'h0000;
    logic              ptr_wr   = 1'b0;
    logic [PTR_W-1:0]  ptr_data = 21'h000000;
    logic [7:0]        file_data;
    logic [15:0]       pm_data;
    logic [1:0]        quarter;
    logic              busy, file_rd, indexed, file_wr, wreg_wr, pm_rd, done;
    logic [ADDR_W-1:0] file_addr;
    logic [7:0]        result, latch;
    logic [PTR_W-2:0]  pm_addr;
    logic [PTR_W-1:0]  ptr;
    int                miscompares = 0;
    int                check_count = 0;
    int                cycles      = 0;

    nstre_exec dut (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .INSTR_VALID_IN(valid),
        .INSTR_IN(instr), .BANK_SELECT_IN(bank), .EXT_SET_EN_IN(ext), .INDEX_BASE_IN(base),
        .FILE_RD_DATA_IN(file_data), .PM_DATA_IN(pm_data), .PTR_WR_EN_IN(ptr_wr),
        .PTR_WR_DATA_IN(ptr_data), .QUARTER_OUT(quarter), .BUSY_OUT(busy),
        .FILE_RD_EN_OUT(file_rd), .FILE_ADDR_OUT(file_addr), .INDEXED_OUT(indexed),
        .FILE_WR_EN_OUT(file_wr), .WREG_WR_EN_OUT(wreg_wr), .RESULT_OUT(result),
        .PM_RD_EN_OUT(pm_rd), .PM_WORD_ADDR_OUT(pm_addr), .TABLE_DONE_OUT(done),
        .TABLE_LATCH_OUT(latch), .TABLE_POINTER_OUT(ptr));

    nstre_core_model model (.clk_in(clk), .file_rd_en_in(file_rd), .file_addr_in(file_addr),
        .pm_rd_en_in(pm_rd), .pm_word_addr_in(pm_addr), .file_data_out(file_data),
        .pm_data_out(pm_data));

    // ------------------------------------------------------------------
    // Clock, watchdog, reporting
    // ------------------------------------------------------------------
    always #5 clk = ~clk;

    // Whole run needs about 120 cycles; ceiling leaves wide margin
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            summarize();
        end
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Drivers: called and left at a falling edge
    // ------------------------------------------------------------------
    // Waits for an idle first quarter, then offers one word for one edge
    task automatic offer(input logic [15:0] word);
        int n;
        n = 0;
        while ((quarter !== QTR_1 || busy !== 1'b0) && n < 16) begin
            @(negedge clk);
            n++;
        end
        valid = 1'b1;
        instr = word;
        @(negedge clk);
        valid = 1'b0;
    endtask

    task automatic load_ptr(input logic [PTR_W-1:0] p);
        ptr_wr   = 1'b1;
        ptr_data = p;
        @(negedge clk);
        ptr_wr = 1'b0;
        chk("ptr_load", ptr, p);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic swap_case(input logic [15:0] word, input logic [5:0] bsel,
                             input logic xen, input logic [ADDR_W-1:0] xbase,
                             input logic [ADDR_W-1:0] addr_e, input logic idx_e);
        logic [7:0] b;
        b    = addr_e[7:0] ^ 8'ha5;
        bank = bsel;
        ext  = xen;
        base = xbase;
        offer(word);
        chk("file_rd", file_rd, 1);
        chk("file_addr", file_addr, addr_e);
        chk("indexed", indexed, idx_e);
        @(negedge clk);
        chk("result", result, {b[3:0], b[7:4]});
        chk("early_wr", {file_wr, wreg_wr}, 0);
        @(negedge clk);
        chk("file_wr", file_wr, word[DEST_BIT]);
        chk("wreg_wr", wreg_wr, !word[DEST_BIT]);
        @(negedge clk);
        chk("swap_busy", {busy, file_wr, wreg_wr}, 0);
        $display("Swap %h done", word);
    endtask

    // Pointer may be loaded first or carried over for back-to-back reads
    task automatic table_case(input logic [1:0] mode, input logic [PTR_W-1:0] p,
                              input logic ld);
        logic [PTR_W-1:0] eff;
        logic [PTR_W-1:0] fin;
        logic [15:0]      w;
        eff = (mode == MODE_PRE_INC) ? p + 21'h000001 : p;
        fin = (mode == MODE_POST_INC) ? p + 21'h000001 :
              (mode == MODE_POST_DEC) ? p - 21'h000001 : eff;
        w   = {eff[8:1] ^ 8'h96, eff[8:1] ^ 8'h3c};
        if (ld) begin
            load_ptr(p);
        end
        offer({14'h0002, mode});
        repeat (3) @(negedge clk);
        chk("pm_rd_early", pm_rd, 0);
        @(negedge clk);
        chk("pm_rd", pm_rd, 1);
        chk("pm_addr", pm_addr, eff[20:1]);
        @(negedge clk);
        chk("done_early", done, 0);
        @(negedge clk);
        chk("done", done, 1);
        chk("latch", latch, eff[0] ? w[15:8] : w[7:0]);
        chk("pointer", ptr, fin);
        @(negedge clk);
        chk("tbl_busy", busy, 0);
        $display("Table read mode %0d from %h done", mode, p);
    endtask

    // Foreign words and pointer loads during a swap must leave no trace
    task automatic refuse_case();
        logic [15:0] bad [3];
        bad = '{16'h000c, 16'h3c00, 16'h0102};
        foreach (bad[i]) begin
            offer(bad[i]);
            repeat (4) begin
                chk("refused", {busy, file_rd, pm_rd}, 0);
                @(negedge clk);
            end
        end
        load_ptr(21'h012345);
        offer(16'h3b10);
        ptr_wr   = 1'b1;
        ptr_data = 21'h1abcde;
        @(negedge clk);
        ptr_wr = 1'b0;
        repeat (3) @(negedge clk);
        chk("busy_ptr", ptr, 21'h012345);
        $display("Refusal checks done");
    endtask

    // Reset in the middle of a table read must clear everything at once
    task automatic reset_case();
        offer({14'h0002, MODE_POST_INC});
        repeat (2) @(negedge clk);
        rst_n = 1'b0;
        @(negedge clk);
        chk("rst_mid", {quarter, busy, pm_rd, done}, 0);
        chk("rst_ptr", ptr, 21'h000000);
        rst_n = 1'b1;
        $display("Mid-run reset done");
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (16) @(negedge clk);
        chk("reset_flags", {quarter, busy, file_rd, file_wr, wreg_wr, pm_rd, done}, 0);
        chk("reset_ptr", ptr, 21'h000000);
        chk("reset_latch", latch, 8'h00);
        rst_n = 1'b1;
        // First swap is offered in the very first cycle after release
        swap_case(16'h3b53, 6'h15, 1'b1, 14'h0000, 14'h1553, 1'b0);
        swap_case(16'h3860, 6'h15, 1'b1, 14'h0000, 14'h3f60, 1'b0);
        swap_case(16'h3a5f, 6'h2a, 1'b0, 14'h0123, 14'h005f, 1'b0);
        swap_case(16'h385f, 6'h2a, 1'b1, 14'h0123, 14'h0182, 1'b1);
        swap_case(16'h3b00, 6'h3f, 1'b1, 14'h0123, 14'h3f00, 1'b0);
        swap_case(16'h3a40, 6'h2a, 1'b1, 14'h0123, 14'h0163, 1'b1);
        refuse_case();
        reset_case();
        table_case(MODE_KEEP, 21'h00a356, 1'b1);
        table_case(MODE_POST_INC, 21'h1fffff, 1'b1);
        table_case(MODE_POST_DEC, 21'h000000, 1'b0);
        table_case(MODE_PRE_INC, 21'h01a357, 1'b1);
        summarize();
    end
endmodule
